// ---- core/raster_plane_defs.svh ----
`ifndef RASTER_PLANE_DEFS_SVH
`define RASTER_PLANE_DEFS_SVH
// ==========================================================
// word and field geometry
`define RP_WORD_BITS 20
`define RP_ZONE_COUNT 5
`define RP_ZONE_BITS 4
`define RP_WRITE_GROUPS 4
`define RP_ROW_ADDR_BITS 7
// ==========================================================
// register offsets on the plain register port
`define RP_REG_CTRL 4'h0
`define RP_REG_STATUS 4'h4
`define RP_REG_HOLD 4'h8
// ==========================================================
// field positions
`define RP_CTRL_FUNC_LSB 0
`define RP_CTRL_FUNC_MSB 3
`define RP_CTRL_WEN_BIT 4
`define RP_STAT_BUSY_BIT 0
`define RP_STAT_EQUAL_BIT 1
`define RP_STAT_KIND_LSB 2
`define RP_STAT_KIND_MSB 3
`define RP_STAT_REFRESH_BIT 4
// ==========================================================
// reset values and function codes
`define RP_FUNC_RESET 4'hf
`define RP_WEN_RESET 1'b0
`define RP_FUNC_XNOR 4'h9
`define RP_FUNC_PASS_A 4'hf
// ==========================================================
// timing counts
`define RP_SYNC_STAGES 3
`endif

// ---- core/raster_plane_pkg.sv ----
package raster_plane_pkg;
  // cycle kinds, encoded as {cycle_sel_hi, cycle_sel_lo}
  typedef enum logic [1:0] {
    CK_DEST = 2'h0,
    CK_SOURCE = 2'h1,
    CK_READ = 2'h2,
    CK_OPERATE = 2'h3
  } cycle_kind_t;
  // memory cycle sequencer, gray along idle-row-col-data-write
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ROW = 3'h1,
    ST_COL = 3'h3,
    ST_DATA = 3'h2,
    ST_WRITE = 3'h6
  } seq_state_t;
  // all pins from the vector generator and display bus
  typedef struct packed {
    logic [4:0] pixel_pos;
    logic pixel_write_strobe;
    logic serial_pixel_in;
    logic cycle_sel_lo;
    logic cycle_sel_hi;
    logic vector_ack;
    logic refresh;
    logic cycle_req;
    logic [4:0] horiz_word_addr;
    logic [8:0] vert_line_addr;
  } pin_bundle_t;
  // context of the cycle in progress
  typedef struct packed {
    cycle_kind_t kind;
    logic refresh;
    logic [4:0] zone;
    logic [4:0] horiz;
    logic [8:0] vert;
  } cycle_ctx_t;
endpackage : raster_plane_pkg

// ---- core/raster_logic_unit.sv ----
`timescale 1ns/1ps
`include "raster_plane_defs.svh"
// ==========================================================
// sixteen-function bitwise logic unit with wired equality
module raster_logic_unit #(
  parameter int WIDTH = `RP_WORD_BITS
) (
  input wire logic [3:0] func_i,
  input wire logic [WIDTH-1:0] a_i,
  input wire logic [WIDTH-1:0] b_i,
  input wire logic [WIDTH-1:0] active_i,
  input wire logic [WIDTH-1:0] hold_i,
  output logic [WIDTH-1:0] f_o,
  output logic equal_o
);
  // truth table per function, bit index {a,b}
  logic [3:0] table_bits;
  always_comb begin
    unique case (func_i)
      4'h0: table_bits = 4'h3; // not a
      4'h1: table_bits = 4'h1; // a nor b
      4'h2: table_bits = 4'h2; // not a and b
      4'h3: table_bits = 4'h0; // zero
      4'h4: table_bits = 4'h7; // a nand b
      4'h5: table_bits = 4'h5; // not b
      4'h6: table_bits = 4'h6; // a xor b
      4'h7: table_bits = 4'h4; // a and not b
      4'h8: table_bits = 4'hb; // not a or b
      4'h9: table_bits = 4'h9; // a xnor b
      4'ha: table_bits = 4'ha; // b
      4'hb: table_bits = 4'h8; // a and b
      4'hc: table_bits = 4'hf; // one
      4'hd: table_bits = 4'hd; // a or not b
      4'he: table_bits = 4'he; // a or b
      4'hf: table_bits = 4'hc; // a
    endcase
  end
  // per bit: pick table entry, keep stored bit where word not active
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      assign f_o[i] = active_i[i] ? table_bits[{a_i[i], b_i[i]}] : hold_i[i];
    end
  endgenerate
  // wired equality only meaningful under xnor
  // RQ14 all-bit equality
  assign equal_o = (func_i == `RP_FUNC_XNOR) && (a_i == b_i);
endmodule : raster_logic_unit

// ---- core/raster_plane_pixel_datapath.sv ----
`timescale 1ns/1ps
`include "raster_plane_defs.svh"
// Operation
// RQ1: pixel position latched on pixel write strobe
// RQ2: row enables from pixel latches or zones
// RQ3: cycle select decoded into five cycle kinds; the code decodes four, with refresh taken from its own pin
// RQ4: write enable flop gates all write pulses
// RQ5: four write pulses, four column strobes
// RQ6: twenty word positions, four codes unused; the code decodes codes 0-19 and leaves 12 codes unused
// RQ7: pixel word copied to second stage
// RQ8: vector ack never clears second stage
// RQ9: new data from pixels or hold latch
// RQ10: unmodified words leave pixels untouched
// RQ11: four-bit selector picks sixteen functions
// RQ12: codes 0-7 function order
// RQ13: codes 8-f function order
// RQ14: xnor equality high when all equal
// RQ15: hold latch keeps source until destination
// RQ16: hold load high through column, then low
// RQ17: destination forces pass-a function
// RQ18: 14-bit address from bus, registered
// RQ19: row phase then column phase address
// RQ20: cycle select encoding per kind
// RQ21: refresh strobes all rows, no writes
// RQ22: operate writes only enabled positions
// RQ23: block moves use five four-bit fields
// RQ24: writes only with enable and active row
// RQ25: function selector holds until reloaded
module raster_plane_pixel_datapath #(
  parameter int WIDTH = `RP_WORD_BITS,
  parameter int GROUPS = `RP_WRITE_GROUPS
) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic ce_i,
  input wire raster_plane_pkg::pin_bundle_t pins_i,
  input wire logic [WIDTH-1:0] ram_q_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  output logic [WIDTH-1:0] row_strobe_o,
  output logic [GROUPS-1:0] col_strobe_o,
  output logic [GROUPS-1:0] write_pulse_o,
  output logic [`RP_ROW_ADDR_BITS-1:0] ram_addr_o,
  output logic [WIDTH-1:0] ram_d_o,
  output logic hold_load_o,
  output logic equal_o,
  output logic busy_o
);
  localparam int PB = $bits(raster_plane_pkg::pin_bundle_t);
  localparam int GW = WIDTH / GROUPS;

  // ==========================================================
  // pin synchronisers
  logic [PB-1:0] sync1; // first stage, read only by sync2
  logic [PB-1:0] sync2; // second stage
  logic [PB-1:0] sync3; // third stage
  logic [PB-1:0] pin_f; // filtered, changes when 2 and 3 agree
  raster_plane_pkg::pin_bundle_t pin; // filtered view
  raster_plane_pkg::pin_bundle_t pin_d; // previous filtered view
  genvar b;
  generate
    for (b = 0; b < PB; b = b + 1) begin : g_sync
      // three flops, accept only an agreed level
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          sync1[b] <= 1'b0;
          sync2[b] <= 1'b0;
          sync3[b] <= 1'b0;
          pin_f[b] <= 1'b0;
        end else if (ce_i) begin
          sync1[b] <= pins_i[b];
          sync2[b] <= sync1[b];
          sync3[b] <= sync2[b];
          if (sync2[b] == sync3[b]) begin
            pin_f[b] <= sync3[b];
          end
        end
      end
    end
  endgenerate
  assign pin = pin_f;
  // previous filtered levels for edge detection
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_d <= '0;
    end else if (ce_i) begin
      pin_d <= pin;
    end
  end
  // rising edges of the strobes
  wire pix_edge = pin.pixel_write_strobe && !pin_d.pixel_write_strobe;
  wire ack_edge = pin.vector_ack && !pin_d.vector_ack;
  wire req_edge = pin.cycle_req && !pin_d.cycle_req;

  // ==========================================================
  // register port
  logic [3:0] func_sel; // logic unit function selector
  logic write_en; // write enable flip-flop
  wire ctrl_hit = reg_addr_i == `RP_REG_CTRL;
  wire stat_hit = reg_addr_i == `RP_REG_STATUS;
  wire hold_hit = reg_addr_i == `RP_REG_HOLD;
  // control register, held until software reloads
  // RQ25 selector holds value
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      func_sel <= `RP_FUNC_RESET;
      write_en <= `RP_WEN_RESET;
    end else if (ce_i && reg_wr_i && ctrl_hit) begin
      func_sel <= reg_wdata_i[`RP_CTRL_FUNC_MSB:`RP_CTRL_FUNC_LSB];
      write_en <= reg_wdata_i[`RP_CTRL_WEN_BIT];
    end
  end

  // ==========================================================
  // pixel assembly, first and second stage
  logic [WIDTH-1:0] pix_data1; // first stage pixel data
  logic [WIDTH-1:0] pix_en1; // first stage position flags
  logic [WIDTH-1:0] pix_data2; // second stage pixel data
  logic [WIDTH-1:0] pix_en2; // second stage position flags
  // chip select from top bits, output from low bits
  wire [1:0] chip_sel = pin.pixel_pos[4:3];
  wire [2:0] chip_out = pin.pixel_pos[2:0];
  wire [4:0] pos_index = {chip_sel, chip_out};
  genvar p;
  generate
    for (p = 0; p < WIDTH; p = p + 1) begin : g_pix
      // RQ6 decode one position
      wire hit = pix_edge && (pos_index == 5'(p));
      // RQ1 latch on strobe, set wins over ack clear
      always_ff @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
          pix_data1[p] <= 1'b0;
          pix_en1[p] <= 1'b0;
        end else if (ce_i) begin
          if (hit) begin
            pix_data1[p] <= pin.serial_pixel_in;
            pix_en1[p] <= 1'b1;
          end else if (ack_edge) begin
            pix_data1[p] <= 1'b0;
            pix_en1[p] <= 1'b0;
          end
        end
      end
    end
  endgenerate

  // ==========================================================
  // cycle sequencer
  raster_plane_pkg::seq_state_t state;
  raster_plane_pkg::seq_state_t next_state;
  raster_plane_pkg::cycle_ctx_t ctx; // cycle in progress
  // RQ3 decode cycle select
  // RQ20 encoding hi,lo
  wire [1:0] sel_code = {pin.cycle_sel_hi, pin.cycle_sel_lo};
  wire start = (state == raster_plane_pkg::ST_IDLE) && req_edge;
  always_comb begin
    unique case (state)
      raster_plane_pkg::ST_IDLE: next_state = start ? raster_plane_pkg::ST_ROW : raster_plane_pkg::ST_IDLE;
      raster_plane_pkg::ST_ROW: next_state = raster_plane_pkg::ST_COL;
      raster_plane_pkg::ST_COL: next_state = raster_plane_pkg::ST_DATA;
      raster_plane_pkg::ST_DATA: next_state = raster_plane_pkg::ST_WRITE;
      raster_plane_pkg::ST_WRITE: next_state = raster_plane_pkg::ST_IDLE;
      default: next_state = raster_plane_pkg::ST_IDLE;
    endcase
  end
  // state and cycle context capture
  // RQ18 address registered from bus
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state <= raster_plane_pkg::ST_IDLE;
      ctx <= '0;
    end else if (ce_i) begin
      state <= next_state;
      if (start) begin
        ctx <= {raster_plane_pkg::cycle_kind_t'(sel_code), pin.refresh,
                pin.pixel_pos, pin.horiz_word_addr, pin.vert_line_addr};
      end
    end
  end
  // RQ7 copy word to second stage
  // RQ8 ack never clears this stage
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pix_data2 <= '0;
      pix_en2 <= '0;
    end else if (ce_i && start && !pin.refresh) begin
      pix_data2 <= pix_data1;
      pix_en2 <= pix_en1;
    end
  end

  // ==========================================================
  // row enable selection
  wire is_move = (ctx.kind == raster_plane_pkg::CK_DEST) || (ctx.kind == raster_plane_pkg::CK_SOURCE);
  wire [WIDTH-1:0] zone_en; // five fields of four bits
  genvar z;
  generate
    // RQ23 field designators
    for (z = 0; z < WIDTH; z = z + 1) begin : g_zone
      assign zone_en[z] = ctx.zone[z / `RP_ZONE_BITS];
    end
  endgenerate
  // RQ2 pixel latches or zones
  // RQ21 refresh strobes every row
  wire [WIDTH-1:0] row_en = ctx.refresh ? {WIDTH{1'b1}} : (is_move ? zone_en : pix_en2);
  wire [`RP_ROW_ADDR_BITS-1:0] row_addr = {ctx.horiz, ctx.vert[2:1]};
  wire [`RP_ROW_ADDR_BITS-1:0] col_addr = {ctx.vert[8:3], ctx.vert[0]};

  // ==========================================================
  // logic unit and hold latch
  logic [WIDTH-1:0] hold; // block-move holding latch
  wire is_dest = ctx.kind == raster_plane_pkg::CK_DEST;
  // RQ17 destination forces pass-a
  wire [3:0] func_eff = is_dest ? `RP_FUNC_PASS_A : func_sel;
  // RQ9 new data source select
  wire [WIDTH-1:0] alu_a = is_dest ? hold : pix_data2;
  // RQ10 only an active word is modified
  wire word_active = !ctx.refresh && (ctx.kind != raster_plane_pkg::CK_READ);
  wire [WIDTH-1:0] alu_active = word_active ? row_en : '0;
  wire [WIDTH-1:0] alu_f;
  wire alu_eq;
  // RQ11 selector drives function
  // RQ12 low codes
  // RQ13 high codes
  raster_logic_unit #(
    .WIDTH(WIDTH)
  ) i_raster_logic_unit (
    .func_i(func_eff),
    .a_i(alu_a),
    .b_i(ram_q_i),
    .active_i(alu_active),
    .hold_i(ram_q_i),
    .f_o(alu_f),
    .equal_o(alu_eq)
  );
  // RQ15 hold source word
  // RQ16 capture as load goes low
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold <= '0;
    end else if (ce_i && state == raster_plane_pkg::ST_DATA && ctx.kind == raster_plane_pkg::CK_SOURCE
                 && !ctx.refresh) begin
      hold <= ram_q_i;
    end
  end

  // ==========================================================
  // write qualification per group
  wire [GROUPS-1:0] group_en;
  genvar g;
  generate
    for (g = 0; g < GROUPS; g = g + 1) begin : g_grp
      assign group_en[g] = |row_en[g*GW +: GW];
    end
  endgenerate
  // RQ4 write enable flop gates
  // RQ22 only enabled positions
  // RQ24 enable and active row
  wire [GROUPS-1:0] next_write = (write_en && word_active) ? group_en : '0;
  wire in_source = (state == raster_plane_pkg::ST_ROW) || (state == raster_plane_pkg::ST_COL);
  wire next_hold_load = (ctx.kind == raster_plane_pkg::CK_SOURCE) && in_source && !ctx.refresh;

  // ==========================================================
  // memory-side outputs, all registered
  // RQ5 write pulses, column strobes
  // RQ19 row then column address
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      row_strobe_o <= '0;
      col_strobe_o <= '0;
      write_pulse_o <= '0;
      ram_addr_o <= '0;
      ram_d_o <= '0;
      hold_load_o <= 1'b0;
      equal_o <= 1'b0;
      busy_o <= 1'b0;
    end else if (ce_i) begin
      busy_o <= next_state != raster_plane_pkg::ST_IDLE;
      hold_load_o <= next_hold_load;
      write_pulse_o <= '0;
      unique case (state)
        raster_plane_pkg::ST_IDLE: begin
          row_strobe_o <= '0;
          col_strobe_o <= '0;
          if (start) begin
            ram_addr_o <= {pin.horiz_word_addr, pin.vert_line_addr[2:1]};
          end
        end
        raster_plane_pkg::ST_ROW: begin
          row_strobe_o <= row_en;
          ram_addr_o <= col_addr;
        end
        raster_plane_pkg::ST_COL: begin
          col_strobe_o <= {GROUPS{1'b1}};
        end
        raster_plane_pkg::ST_DATA: begin
          ram_d_o <= alu_f;
          equal_o <= alu_eq;
          write_pulse_o <= next_write;
        end
        raster_plane_pkg::ST_WRITE: begin
          row_strobe_o <= '0;
          col_strobe_o <= '0;
        end
        default: begin
          row_strobe_o <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // register read, data one cycle after the strobe
  wire [31:0] stat_word = {27'h0, ctx.refresh, ctx.kind, equal_o, busy_o};
  wire [31:0] next_rdata = !reg_rd_i ? 32'h0 :
                           ctrl_hit ? {27'h0, write_en, func_sel} :
                           stat_hit ? stat_word :
                           hold_hit ? {12'h0, hold} : 32'h0;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      reg_rdata_o <= '0;
    end else if (ce_i) begin
      reg_rdata_o <= next_rdata;
    end
  end

  // ==========================================================
  // assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i || !ce_i);

  property p_refresh_nowrite;
    ctx.refresh |-> write_pulse_o == '0;
  endproperty
  a_refresh_nowrite: assert property (p_refresh_nowrite) else $error("write during refresh"); // RQ21

  property p_refresh_allrows;
    state == raster_plane_pkg::ST_COL && ctx.refresh |-> row_strobe_o == {WIDTH{1'b1}};
  endproperty
  a_refresh_allrows: assert property (p_refresh_allrows) else $error("refresh missed rows"); // RQ21

  property p_wen_gate;
    !write_en ##1 !write_en |-> write_pulse_o == '0;
  endproperty
  a_wen_gate: assert property (p_wen_gate) else $error("write pulse while disabled"); // RQ4

  property p_read_nowrite;
    ctx.kind == raster_plane_pkg::CK_READ |-> write_pulse_o == '0;
  endproperty
  a_read_nowrite: assert property (p_read_nowrite) else $error("write in read cycle"); // RQ3

  property p_dest_pass;
    state == raster_plane_pkg::ST_DATA && is_dest && !ctx.refresh
      |=> (ram_d_o & $past(row_en)) == ($past(hold) & $past(row_en));
  endproperty
  a_dest_pass: assert property (p_dest_pass) else $error("destination data altered"); // RQ17

  property p_addr_phases;
    start |=> ram_addr_o == row_addr ##1 ram_addr_o == col_addr;
  endproperty
  a_addr_phases: assert property (p_addr_phases) else $error("address phase wrong"); // RQ19

  property p_hold_stable;
    is_dest && busy_o |-> $stable(hold);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("hold changed in destination"); // RQ15

  property p_ack_keeps;
    ack_edge && !start |=> $stable(pix_data2);
  endproperty
  a_ack_keeps: assert property (p_ack_keeps) else $error("second stage cleared"); // RQ8

  property p_pulse_once;
    write_pulse_o != '0 |=> write_pulse_o == '0 && busy_o == 1'b0;
  endproperty
  a_pulse_once: assert property (p_pulse_once) else $error("write pulse too long"); // RQ5

  property p_equal;
    state == raster_plane_pkg::ST_DATA && func_eff == `RP_FUNC_XNOR && alu_a == ram_q_i |=> equal_o;
  endproperty
  a_equal: assert property (p_equal) else $error("equality not reported"); // RQ14

  property p_hold_load;
    start && sel_code == 2'h1 && !pin.refresh |=> !hold_load_o ##1 hold_load_o [*2] ##1 !hold_load_o;
  endproperty
  a_hold_load: assert property (p_hold_load) else $error("hold load timing"); // RQ16

  c_operate_write: cover property (ctx.kind == raster_plane_pkg::CK_OPERATE && write_pulse_o != '0);
  c_source_dest: cover property (ctx.kind == raster_plane_pkg::CK_SOURCE ##[1:40] is_dest && write_pulse_o != '0);
  c_refresh: cover property (ctx.refresh && state == raster_plane_pkg::ST_COL);
endmodule : raster_plane_pixel_datapath

// ---- testbench/raster_ram_model.sv ----
`timescale 1ns/1ps
// ==========================================================
// memory plane model: twenty one-bit rams behind the strobes
module raster_ram_model (
  input wire logic clock_i,
  input wire logic [19:0] row_strobe_i,
  input wire logic [3:0] col_strobe_i,
  input wire logic [3:0] write_pulse_i,
  input wire logic [6:0] ram_addr_i,
  input wire logic [19:0] ram_d_i,
  output logic [19:0] ram_q_o
);
  logic [19:0] mem [0:16383]; // word store
  logic [6:0] addr_d = 7'h00; // address of the previous cycle
  logic [13:0] key = 14'h0000; // latched row and column address
  logic row_d = 1'b0; // any row strobe last cycle
  logic [19:0] q_last = 20'h00000; // last read data shown
  // arbitrary start pattern, distinct per word
  initial begin
    for (int i = 0; i < 16384; i++) begin
      mem[i] = {i[13:0], i[5:0]} ^ 20'h5a5a5;
    end
  end
  // a bit drives data only with its row and a column strobe, else it toggles
  always_comb begin
    for (int b = 0; b < 20; b++) begin
      ram_q_o[b] = (|col_strobe_i && row_strobe_i[b]) ? mem[key][b] : ~q_last[b];
    end
  end
  // row address taken from the cycle before the row strobe, column with it
  always @(posedge clock_i) begin
    addr_d <= ram_addr_i;
    row_d <= |row_strobe_i;
    q_last <= ram_q_o;
    if (|row_strobe_i && !row_d) begin
      key <= {addr_d, ram_addr_i};
    end
    // a write needs row, column and write pulse of its group
    for (int b = 0; b < 20; b++) begin
      if (write_pulse_i[b / 5] && row_strobe_i[b] && |col_strobe_i) begin
        mem[key][b] <= ram_d_i[b];
      end
    end
  end
endmodule : raster_ram_model

// ---- testbench/tb_raster_plane_pixel_datapath.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin error_cnt++; $display("unexpected at %0t: %h %h", $time, (a), (b)); end end
// ==========================================================
// bench for the raster plane pixel datapath
module tb_raster_plane_pixel_datapath;
  logic clock_i = 1'b0; // 40 MHz clock
  logic nrst_i = 1'b0; // active-low reset
  raster_plane_pkg::pin_bundle_t pins = '0; // bus pins
  logic [3:0] reg_addr = 4'h0; // register port
  logic [31:0] reg_wdata = 32'h0;
  logic wr_s = 1'b0;
  logic rd_s = 1'b0;
  logic [31:0] rdata; // design outputs
  logic [19:0] ram_q, rs_o, d_o;
  logic [3:0] cs_o, wp_o;
  logic [6:0] addr_o;
  logic hl_o, eq_o, busy;
  logic [19:0] rs, d; // values captured in a memory cycle
  logic [3:0] wp;
  logic [2:0] hl;
  logic eq;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  localparam logic [19:0] en_pix = 20'h80221; // positions 0, 5, 9, 19
  localparam logic [19:0] a_pix = 20'h80201; // pixel data at those
  localparam logic [19:0] zn = 20'hf0f0f; // fields 0, 2, 4
  localparam logic [13:0] wa = 14'h1d6b; // operate word
  raster_plane_pixel_datapath i_raster_plane_pixel_datapath (.clock_i(clock_i), .nrst_i(nrst_i), .ce_i(1'b1),
    .pins_i(pins), .ram_q_i(ram_q), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(wr_s),
    .reg_rd_i(rd_s), .reg_rdata_o(rdata), .row_strobe_o(rs_o), .col_strobe_o(cs_o), .write_pulse_o(wp_o),
    .ram_addr_o(addr_o), .ram_d_o(d_o), .hold_load_o(hl_o), .equal_o(eq_o), .busy_o(busy));
  raster_ram_model i_raster_ram_model (.clock_i(clock_i), .row_strobe_i(rs_o), .col_strobe_i(cs_o),
    .write_pulse_i(wp_o), .ram_addr_i(addr_o), .ram_d_i(d_o), .ram_q_o(ram_q));
  // clock generator
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  // hang guard
  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // model word index of a screen address
  function automatic logic [13:0] key(input logic [13:0] a);
    key = {a[13:9], a[2:1], a[8:3], a[0]};
  endfunction : key
  // expected logic unit result
  function automatic logic [19:0] alu(input logic [3:0] f, input logic [19:0] a, input logic [19:0] b);
    case (f)
      4'h0: alu = ~a;
      4'h1: alu = ~(a | b);
      4'h2: alu = ~a & b;
      4'h3: alu = 20'h00000;
      4'h4: alu = ~(a & b);
      4'h5: alu = ~b;
      4'h6: alu = a ^ b;
      4'h7: alu = a & ~b;
      4'h8: alu = ~a | b;
      4'h9: alu = ~(a ^ b);
      4'ha: alu = b;
      4'hb: alu = a & b;
      4'hc: alu = 20'hfffff;
      4'hd: alu = a | ~b;
      4'he: alu = a | b;
      default: alu = a;
    endcase
  endfunction : alu
  task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clock_i);
    reg_addr <= a;
    reg_wdata <= v;
    wr_s <= 1'b1;
    @(posedge clock_i);
    wr_s <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clock_i);
    reg_addr <= a;
    rd_s <= 1'b1;
    @(posedge clock_i);
    rd_s <= 1'b0;
    #1 v = rdata;
  endtask : reg_rd
  task automatic pix(input logic [4:0] pos, input logic b);
    @(posedge clock_i);
    pins.pixel_pos <= pos;
    pins.serial_pixel_in <= b;
    repeat (6) @(posedge clock_i);
    pins.pixel_write_strobe <= 1'b1;
    repeat (6) @(posedge clock_i);
    pins.pixel_write_strobe <= 1'b0;
    repeat (6) @(posedge clock_i);
  endtask : pix
  // one memory cycle of a kind, walked phase by phase
  task automatic mc(input logic [1:0] k, input logic rf, input logic [13:0] a, input logic [4:0] pos);
    int i;
    @(posedge clock_i);
    {pins.cycle_sel_hi, pins.cycle_sel_lo} <= k;
    pins.refresh <= rf;
    pins.horiz_word_addr <= a[13:9];
    pins.vert_line_addr <= a[8:0];
    pins.pixel_pos <= pos;
    repeat (6) @(posedge clock_i);
    pins.cycle_req <= 1'b1;
    for (i = 0; i < 20 && busy !== 1'b1; i++) begin
      @(posedge clock_i);
      #1;
    end
    `CHK(addr_o, {a[13:9], a[2:1]})
    hl[0] = hl_o;
    @(posedge clock_i);
    #1 `CHK(addr_o, {a[8:3], a[0]})
    rs = rs_o;
    hl[1] = hl_o;
    @(posedge clock_i);
    #1 `CHK(cs_o, 4'hf)
    hl[2] = hl_o;
    @(posedge clock_i);
    #1 wp = wp_o;
    d = d_o;
    eq = eq_o;
    @(posedge clock_i);
    #1 `CHK({busy, wp_o, rs_o}, 25'h0)
    @(posedge clock_i);
    pins.cycle_req <= 1'b0;
    repeat (5) @(posedge clock_i);
  endtask : mc
  // reset values, read-only and unmapped places
  task automatic t_regs();
    logic [31:0] v;
    reg_wr(4'h4, 32'hffffffff);
    reg_wr(4'hc, 32'h0000001f);
    reg_rd(4'h0, v);
    `CHK(v, 32'h0000000f)
    reg_rd(4'h4, v);
    `CHK(v, 32'h0)
    reg_rd(4'hc, v);
    `CHK(v, 32'h0)
  endtask : t_regs
  // writes disabled: no pulses, memory untouched
  task automatic t_noen();
    logic [19:0] old;
    reg_wr(4'h0, 32'h00000006);
    old = i_raster_ram_model.mem[key(wa)];
    mc(2'h3, 1'b0, wa, 5'h00);
    `CHK(rs, en_pix)
    `CHK(wp, 4'h0)
    `CHK(i_raster_ram_model.mem[key(wa)], old)
  endtask : t_noen
  // every function code on an operate cycle
  task automatic t_funcs();
    logic [19:0] old;
    logic [31:0] v;
    for (int f = 0; f < 16; f++) begin
      reg_wr(4'h0, {27'h0, 1'b1, f[3:0]});
      old = i_raster_ram_model.mem[key(wa)];
      mc(2'h3, 1'b0, wa, 5'h00);
      `CHK(rs, en_pix)
      `CHK(wp, 4'b1011)
      `CHK(d & en_pix, alu(f[3:0], a_pix, old) & en_pix)
      `CHK(i_raster_ram_model.mem[key(wa)] & ~en_pix, old & ~en_pix)
      // bit 5 differs after the previous code
      if (f == 9) `CHK(eq, 1'b0)
      reg_rd(4'h0, v);
      `CHK(v[4:0], {1'b1, f[3:0]})
    end
  endtask : t_funcs
  // refresh and read never write
  task automatic t_kinds();
    mc(2'h3, 1'b1, 14'h0040, 5'h00);
    `CHK({rs, wp}, 24'hfffff0)
    mc(2'h2, 1'b0, 14'h0040, 5'h00);
    `CHK({rs, wp}, {en_pix, 4'h0})
  endtask : t_kinds
  // block move source then destination on zone fields
  task automatic t_move();
    logic [31:0] v;
    logic [19:0] src;
    src = i_raster_ram_model.mem[key(14'h0123)];
    reg_wr(4'h0, 32'h0000000f);
    mc(2'h1, 1'b0, 14'h0123, 5'h15);
    `CHK(rs, zn)
    `CHK(hl, 3'b110)
    reg_rd(4'h8, v);
    `CHK(v[19:0] & zn, src & zn)
    // function not-a must be overridden
    reg_wr(4'h0, 32'h00000010);
    mc(2'h0, 1'b0, 14'h2a55, 5'h15);
    `CHK(hl, 3'b000)
    `CHK(wp, 4'hf)
    `CHK(d & zn, src & zn)
    `CHK(i_raster_ram_model.mem[key(14'h2a55)] & zn, src & zn)
  endtask : t_move
  // acknowledge empties the pixel word for the next cycle
  task automatic t_ack();
    @(posedge clock_i);
    pins.vector_ack <= 1'b1;
    repeat (6) @(posedge clock_i);
    pins.vector_ack <= 1'b0;
    repeat (6) @(posedge clock_i);
    mc(2'h3, 1'b0, wa, 5'h00);
    `CHK({rs, wp}, 24'h0)
  endtask : t_ack
  // main sequence
  initial begin
    repeat (10) @(posedge clock_i);
    nrst_i <= 1'b1;
    t_regs();
    pix(5'd0, 1'b1);
    pix(5'd5, 1'b0);
    pix(5'd9, 1'b1);
    pix(5'd19, 1'b1);
    pix(5'd22, 1'b1);
    t_noen();
    t_funcs();
    t_kinds();
    t_move();
    t_ack();
    give_verdict();
  end
endmodule : tb_raster_plane_pixel_datapath
